/* shared/hgb_pkg.sv */
package hgb_pkg;

   localparam logic [3:0] OFF_G_DIR = 4'h0;
   localparam logic [3:0] OFF_G_IN = 4'h1;
   localparam logic [3:0] OFF_G_OUT = 4'h2;
   localparam logic [3:0] OFF_H_DIR = 4'h3;
   localparam logic [3:0] OFF_H_IN = 4'h4;
   localparam logic [3:0] OFF_H_OUT = 4'h5;
   localparam logic [3:0] OFF_I_DIR = 4'h6;
   localparam logic [3:0] OFF_I_IN = 4'h7;
   localparam logic [3:0] OFF_I_OUT = 4'h8;
   localparam logic [3:0] OFF_LAST = 4'h8;

   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;

   localparam int SEL_G_BIT = 0;
   localparam int SEL_H_BIT = 1;
   localparam int SEL_I_BIT = 2;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } hgb_io_req_s;

   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] out;
   } hgb_ctrl_s;

endpackage : hgb_pkg

/* rtl/hgb_pin_cell.sv */
`timescale 1ns/1ps
// Resolves one eight-pin group to its driven level and enable, registered.
module hgb_pin_cell (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic host_sel,
   input wire logic main_supply_valid,
   input hgb_pkg::hgb_ctrl_s host_ctrl,
   input hgb_pkg::hgb_ctrl_s ec_ctrl,
   input wire logic pass_en,
   input wire logic pass_drive,
   input wire logic [7:0] pass_level,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe
);

   logic [7:0] out_q;
   logic [7:0] out_d;
   logic [7:0] oe_q;
   logic [7:0] oe_d;

   always_comb begin
      if (pass_en) begin
         // Pass-through routing wins over either register source.
         out_d = pass_level;
         oe_d = pass_drive ? 8'hff : 8'h00;
      end else if (host_sel) begin
         out_d = host_ctrl.out;
         // Host-sourced pins float while the main supply is down.
         oe_d = main_supply_valid ? host_ctrl.dir : 8'h00;
      end else begin
         out_d = ec_ctrl.out;
         oe_d = ec_ctrl.dir;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_q <= hgb_pkg::RST_LATCH;
         oe_q <= hgb_pkg::RST_DIR;
      end else begin
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign pin_out = out_q;
   assign pin_oe = oe_q;

endmodule : hgb_pin_cell

/* rtl/hgb_bank.sv */
`timescale 1ns/1ps
// How it works
// - Base plus one reads the live levels of group G pins 0 to 7 and cannot be written.
// - Base plus two is the group G output latch, cleared at reset, driving the output pins while group G is host-sourced and pass-through is off.
// - Group H bits D0 to D7 map to its lowest to highest pin in every register.
// - Base plus three is the group H direction, cleared at reset, one meaning output.
// - Base plus four reads the present group H pin levels and ignores writes.
// - Base plus five is the group H output latch, cleared at reset.
// - When pass-through is enabled, group G levels route onto group H over the registers.
// - Group I bit n maps to group I pin n.
// - Base plus six is the group I direction, cleared at reset, one meaning output.
// - Base plus seven reads the current group I pin levels.
// - Base plus eight is the group I output latch, cleared at reset.
// - Per-group source-select bits choose host registers or controller-side registers.
// - Host accesses work whatever the source-select bits say, while the bank is active.
// - A host-sourced pin floats as input whenever the main supply is not valid, except group H while pass-through drives it.
module hgb_bank (
   input wire logic core_clk,
   input wire logic reset_n,
   input hgb_pkg::hgb_io_req_s io_req,
   input wire logic [15:0] bank_base,
   input wire logic bank_active,
   input wire logic [2:0] pin_source_select,
   input wire logic main_supply_valid,
   input wire logic pass_through_en,
   input hgb_pkg::hgb_ctrl_s ec_g_ctrl,
   input hgb_pkg::hgb_ctrl_s ec_h_ctrl,
   input hgb_pkg::hgb_ctrl_s ec_i_ctrl,
   input wire logic [7:0] g_pin_in,
   input wire logic [7:0] h_pin_in,
   input wire logic [7:0] i_pin_in,
   output logic [7:0] g_pin_out,
   output logic [7:0] g_pin_oe,
   output logic [7:0] h_pin_out,
   output logic [7:0] h_pin_oe,
   output logic [7:0] i_pin_out,
   output logic [7:0] i_pin_oe,
   output logic [7:0] io_rdata,
   output logic io_claim
);

   // Only address bits 15..4 of the base are compared, so a misaligned base
   // simply behaves as its aligned value.
   function automatic logic bank_hit(input logic [15:0] addr, input logic [15:0] base,
                                     input logic active);
      bank_hit = active && (addr[15:4] == base[15:4]) &&
                 (addr[3:0] <= hgb_pkg::OFF_LAST);
   endfunction : bank_hit

   logic hit;
   logic [3:0] off;
   logic [7:0] g_dir_q, g_dir_d, g_out_q, g_out_d;
   logic [7:0] h_dir_q, h_dir_d, h_out_q, h_out_d;
   logic [7:0] i_dir_q, i_dir_d, i_out_q, i_out_d;
   logic [7:0] rdata_q, rdata_d;
   logic claim_q, claim_d;

   assign hit = bank_hit(io_req.addr, bank_base, bank_active);
   assign off = io_req.addr[3:0];

   always_comb begin
      g_dir_d = g_dir_q;
      g_out_d = g_out_q;
      h_dir_d = h_dir_q;
      h_out_d = h_out_q;
      i_dir_d = i_dir_q;
      i_out_d = i_out_q;
      // Source-select does not gate access at all.
      if (io_req.wr && hit) begin
         case (off)
            hgb_pkg::OFF_G_DIR: g_dir_d = io_req.wdata;
            hgb_pkg::OFF_G_OUT: g_out_d = io_req.wdata;
            hgb_pkg::OFF_H_DIR: h_dir_d = io_req.wdata;
            hgb_pkg::OFF_H_OUT: h_out_d = io_req.wdata;
            hgb_pkg::OFF_I_DIR: i_dir_d = io_req.wdata;
            hgb_pkg::OFF_I_OUT: i_out_d = io_req.wdata;
            default: g_dir_d = g_dir_q;
         endcase
      end
   end

   always_comb begin
      rdata_d = hgb_pkg::RST_RDATA;
      claim_d = (io_req.rd || io_req.wr) && hit;
      if (io_req.rd && hit) begin
         case (off)
            hgb_pkg::OFF_G_DIR: rdata_d = g_dir_q;
            hgb_pkg::OFF_G_IN: rdata_d = g_pin_in;
            hgb_pkg::OFF_G_OUT: rdata_d = g_out_q;
            hgb_pkg::OFF_H_DIR: rdata_d = h_dir_q;
            hgb_pkg::OFF_H_IN: rdata_d = h_pin_in;
            hgb_pkg::OFF_H_OUT: rdata_d = h_out_q;
            hgb_pkg::OFF_I_DIR: rdata_d = i_dir_q;
            hgb_pkg::OFF_I_IN: rdata_d = i_pin_in;
            hgb_pkg::OFF_I_OUT: rdata_d = i_out_q;
            default: rdata_d = hgb_pkg::RST_RDATA;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         g_dir_q <= hgb_pkg::RST_DIR;
         g_out_q <= hgb_pkg::RST_LATCH;
         h_dir_q <= hgb_pkg::RST_DIR;
         h_out_q <= hgb_pkg::RST_LATCH;
         i_dir_q <= hgb_pkg::RST_DIR;
         i_out_q <= hgb_pkg::RST_LATCH;
         rdata_q <= hgb_pkg::RST_RDATA;
         claim_q <= 1'b0;
      end else begin
         g_dir_q <= g_dir_d;
         g_out_q <= g_out_d;
         h_dir_q <= h_dir_d;
         h_out_q <= h_out_d;
         i_dir_q <= i_dir_d;
         i_out_q <= i_out_d;
         rdata_q <= rdata_d;
         claim_q <= claim_d;
      end
   end

   assign io_rdata = rdata_q;
   assign io_claim = claim_q;

   // In pass-through, G pins become inputs and their levels appear on H.
   hgb_pin_cell u_cell_g (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .host_sel(pin_source_select[hgb_pkg::SEL_G_BIT]),
      .main_supply_valid(main_supply_valid),
      .host_ctrl({g_dir_q, g_out_q}),
      .ec_ctrl(ec_g_ctrl),
      .pass_en(pass_through_en),
      .pass_drive(1'b0),
      .pass_level(8'h00),
      .pin_out(g_pin_out),
      .pin_oe(g_pin_oe)
   );

   hgb_pin_cell u_cell_h (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .host_sel(pin_source_select[hgb_pkg::SEL_H_BIT]),
      .main_supply_valid(main_supply_valid),
      .host_ctrl({h_dir_q, h_out_q}),
      .ec_ctrl(ec_h_ctrl),
      .pass_en(pass_through_en),
      .pass_drive(1'b1),
      .pass_level(g_pin_in),
      .pin_out(h_pin_out),
      .pin_oe(h_pin_oe)
   );

   hgb_pin_cell u_cell_i (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .host_sel(pin_source_select[hgb_pkg::SEL_I_BIT]),
      .main_supply_valid(main_supply_valid),
      .host_ctrl({i_dir_q, i_out_q}),
      .ec_ctrl(ec_i_ctrl),
      .pass_en(1'b0),
      .pass_drive(1'b0),
      .pass_level(8'h00),
      .pin_out(i_pin_out),
      .pin_oe(i_pin_oe)
   );

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   logic rd_hit, wr_hit;
   assign rd_hit = io_req.rd && hit;
   assign wr_hit = io_req.wr && hit;

   a_g_input_read: assert property (rd_hit && off == hgb_pkg::OFF_G_IN |=>
      io_claim && io_rdata == $past(g_pin_in)) else $error("group G input read wrong");
   a_g_latch_write: assert property (wr_hit && off == hgb_pkg::OFF_G_OUT |=>
      g_out_q == $past(io_req.wdata)) else $error("group G latch not written");
   a_h_dir_drive: assert property (wr_hit && off == hgb_pkg::OFF_H_DIR &&
      pin_source_select[1] && main_supply_valid && !pass_through_en ##1
      (pin_source_select[1] && main_supply_valid && !pass_through_en && !wr_hit) |=>
      h_pin_oe == $past(io_req.wdata, 2)) else $error("group H direction not applied");
   a_h_input_read: assert property (rd_hit && off == hgb_pkg::OFF_H_IN |=>
      io_rdata == $past(h_pin_in)) else $error("group H input read wrong");
   a_h_latch_write: assert property (wr_hit && off == hgb_pkg::OFF_H_OUT |=>
      h_out_q == $past(io_req.wdata)) else $error("group H latch not written");
   a_pass_override: assert property (pass_through_en |=>
      h_pin_oe == 8'hff && g_pin_oe == 8'h00 && h_pin_out == $past(g_pin_in))
      else $error("pass-through did not override");
   a_i_dir_write: assert property (wr_hit && off == hgb_pkg::OFF_I_DIR |=>
      i_dir_q == $past(io_req.wdata)) else $error("group I direction not written");
   a_i_input_read: assert property (rd_hit && off == hgb_pkg::OFF_I_IN |=>
      io_rdata == $past(i_pin_in)) else $error("group I input read wrong");
   a_i_latch_write: assert property (wr_hit && off == hgb_pkg::OFF_I_OUT |=>
      i_out_q == $past(io_req.wdata)) else $error("group I latch not written");
   a_supply_float: assert property (pin_source_select[2] && !main_supply_valid |=>
      i_pin_oe == 8'h00) else $error("host pin driven without main supply");
   a_miss_unclaimed: assert property ((io_req.rd || io_req.wr) && !hit |=>
      !io_claim && io_rdata == 8'h00) else $error("unmapped cycle claimed");
   a_input_write_ignored: assert property (wr_hit && (off == hgb_pkg::OFF_G_IN ||
      off == hgb_pkg::OFF_H_IN || off == hgb_pkg::OFF_I_IN) |=>
      $stable({g_dir_q, g_out_q, h_dir_q, h_out_q, i_dir_q, i_out_q}))
      else $error("input register write changed state");
   a_h_dir_write: assert property (wr_hit && off == hgb_pkg::OFF_H_DIR |=>
      h_dir_q == $past(io_req.wdata)) else $error("group H direction not written");
   a_g_host_drive: assert property (pin_source_select[0] && main_supply_valid &&
      !pass_through_en |=> g_pin_out == $past(g_out_q) && g_pin_oe == $past(g_dir_q))
      else $error("group G pins do not follow host registers");
   a_i_ctrl_select: assert property (!pin_source_select[2] |=>
      i_pin_oe == $past(ec_i_ctrl.dir) && i_pin_out == $past(ec_i_ctrl.out))
      else $error("group I pins do not follow controller registers");
   a_i_host_dir: assert property (pin_source_select[2] && main_supply_valid |=>
      i_pin_oe == $past(i_dir_q)) else $error("group I direction not applied");

   c_host_read: cover property (rd_hit ##1 io_claim);
   c_write_then_drive: cover property (wr_hit && off == hgb_pkg::OFF_G_OUT ##2 g_pin_oe != 8'h00);
   c_pass_through: cover property (pass_through_en [*3]);
   c_supply_loss: cover property (main_supply_valid ##1 !main_supply_valid);

endmodule : hgb_bank

/* verif/hgb_host_model.sv */
`timescale 1ns/1ps
// Host bus owner: one byte per I/O cycle, with the strobe held for exactly one clock.
module hgb_host_model (
   input wire logic core_clk,
   input wire logic [7:0] io_rdata,
   input wire logic io_claim,
   output hgb_pkg::hgb_io_req_s io_req
);
   initial io_req = '0;
   // One to three idle clocks before the strobe space host cycles apart, so they never run back to back.
   task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] wd,
                           input int gap, output logic [7:0] rd, output logic claim);
      repeat (gap) @(negedge core_clk);
      @(negedge core_clk);
      io_req.addr = addr;
      io_req.wdata = wr ? wd : ~wd;
      io_req.wr = wr;
      io_req.rd = ~wr;
      @(negedge core_clk);
      rd = io_rdata;
      claim = io_claim;
      io_req.rd = 1'b0;
      io_req.wr = 1'b0;
      // A released address and data bus must not keep looking valid.
      io_req.addr = ~addr;
      io_req.wdata = ~wd;
   endtask : io_cycle
endmodule : hgb_host_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   hgb_pkg::hgb_io_req_s io_req;
   logic [15:0] bank_base = 16'h0a30;
   logic bank_active = 1'b1;
   logic [2:0] pin_source_select = 3'h7;
   logic main_supply_valid = 1'b1;
   logic pass_through_en = 1'b0;
   hgb_pkg::hgb_ctrl_s ec [3] = '{default: '0};
   logic [7:0] pin_in [3] = '{default: 8'h00};
   logic [7:0] pin_out [3];
   logic [7:0] pin_oe [3];
   logic [7:0] io_rdata;
   logic io_claim;
   logic [7:0] ex [9];
   int fail_count = 0;
   int n_compared = 0;

   always #10 core_clk = ~core_clk;

   hgb_bank i_hgb_bank (.core_clk(core_clk), .reset_n(reset_n), .io_req(io_req),
      .bank_base(bank_base), .bank_active(bank_active), .pin_source_select(pin_source_select),
      .main_supply_valid(main_supply_valid), .pass_through_en(pass_through_en),
      .ec_g_ctrl(ec[0]), .ec_h_ctrl(ec[1]), .ec_i_ctrl(ec[2]), .g_pin_in(pin_in[0]),
      .h_pin_in(pin_in[1]), .i_pin_in(pin_in[2]), .g_pin_out(pin_out[0]), .g_pin_oe(pin_oe[0]),
      .h_pin_out(pin_out[1]), .h_pin_oe(pin_oe[1]), .i_pin_out(pin_out[2]),
      .i_pin_oe(pin_oe[2]), .io_rdata(io_rdata), .io_claim(io_claim));

   hgb_host_model i_hgb_host_model (.core_clk(core_clk), .io_rdata(io_rdata),
      .io_claim(io_claim), .io_req(io_req));

   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      n_compared++;
      if (got !== want) begin
         $display("Error at %0t: got %h expected %h", $time, got, want);
         fail_count++;
      end
   endtask : chk

   // Input offsets return the pin levels, the others the last value written.
   function automatic logic [7:0] exp_rd(input logic [3:0] off);
      if (off == 4'h1 || off == 4'h4 || off == 4'h7) return pin_in[off / 3];
      return ex[off];
   endfunction : exp_rd

   task automatic acc(input logic wr, input logic [15:0] addr, input logic [7:0] wd,
                      input logic hit);
      logic [7:0] rd;
      logic [7:0] want;
      logic claim;
      want = (hit && !wr) ? exp_rd(addr[3:0]) : 8'h00;
      i_hgb_host_model.io_cycle(wr, addr, wd, $urandom_range(2, 0), rd, claim);
      chk({7'h00, claim}, {7'h00, hit});
      chk(rd, want);
      if (hit && wr && addr[3:0] % 3 != 1) ex[addr[3:0]] = wd;
   endtask : acc

   task automatic pins();
      logic [7:0] d;
      logic [7:0] o;
      @(negedge core_clk);
      for (int g = 0; g < 3; g++) begin
         d = pin_source_select[g] ? ex[3 * g] & {8{main_supply_valid}} : ec[g].dir;
         o = pin_source_select[g] ? ex[3 * g + 2] : ec[g].out;
         if (pass_through_en && g == 0) d = 8'h00;
         if (pass_through_en && g == 1) begin
            d = 8'hff;
            o = pin_in[0];
         end
         chk(pin_oe[g], d);
         chk(pin_out[g] & d, o & d);
      end
   endtask : pins

   task automatic do_reset();
      @(negedge core_clk);
      reset_n = 1'b0;
      repeat (8) @(negedge core_clk);
      reset_n = 1'b1;
      foreach (ex[i]) ex[i] = 8'h00;
      for (int i = 0; i < 9; i++) acc(1'b0, {bank_base[15:4], 4'(i)}, 8'h00, 1'b1);
   endtask : do_reset

   initial begin
      logic [15:0] base;
      int off;
      void'($urandom(32'h32478337));
      foreach (pin_in[g]) pin_in[g] = 8'($urandom);
      do_reset();
      for (int i = 0; i < 9; i++) acc(1'b1, {bank_base[15:4], 4'(i)}, 8'hff, 1'b1);
      for (int i = 0; i < 9; i++) acc(1'b0, {bank_base[15:4], 4'(i)}, 8'h00, 1'b1);
      main_supply_valid = 1'b0;
      pins();
      main_supply_valid = 1'b1;
      pins();
      for (int n = 0; n < 300; n++) begin
         foreach (pin_in[g]) pin_in[g] = 8'($urandom);
         foreach (ec[g]) ec[g] = 16'($urandom);
         pin_source_select = 3'($urandom);
         main_supply_valid = $urandom_range(3, 0) != 0;
         pass_through_en = $urandom_range(3, 0) == 0;
         bank_active = $urandom_range(7, 0) != 0;
         off = $urandom_range(15, 0);
         base = $urandom_range(7, 0) == 0 ? 16'h0b30 : bank_base;
         acc(1'($urandom), {base[15:4], 4'(off)}, 8'($urandom),
             bank_active && base == bank_base && off <= 8);
         pins();
      end
      bank_active = 1'b1;
      do_reset();
      test_done();
   end

   // Every wait is bounded, so this only fires if the clock or a task stalls.
   initial begin
      repeat (100000) @(posedge core_clk);
      fail_count++;
      test_done();
   end
endmodule : tb
